//--- hw/csb_cmp_sub.sv
`timescale 1ns/1ps

module csb_cmp_sub
(
	// operands
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	// discarded difference and its flags
	output logic [7:0] res_o,
	output logic c_o,
	output logic h_o,
	output logic v_o,
	output logic n_o,
	output logic z_o
);

	logic [8:0] full;
	logic [4:0] half;

	always_comb
	begin
		full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
		half = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
		res_o = full[7:0];
		c_o = full[8];
		h_o = half[4];
		v_o = (a_i[7] & ~b_i[7] & ~full[7]) | (~a_i[7] & b_i[7] & full[7]);
		n_o = full[7];
		z_o = (full[7:0] == 8'h00);
	end

endmodule

//--- hw/csb_consts.svh
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CSB_ADR_FLAGS 4'h0
`define CSB_ADR_STATUS 4'h4
`define CSB_ADR_CTRL 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSB_FLAG_C 3'h0
`define CSB_FLAG_Z 3'h1
`define CSB_FLAG_N 3'h2
`define CSB_FLAG_V 3'h3
`define CSB_FLAG_H 3'h5
`define CSB_STAT_BUSY 0
`define CSB_STAT_TAKEN 1
`define CSB_STAT_CYC_LO 2
`define CSB_CTRL_EN 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSB_FLAGS_RST 8'h00
`define CSB_CTRL_EN_RST 1'h1

// ----------------------------------------------------------------
// timing in core cycles and program counter steps
// ----------------------------------------------------------------
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_SKIP1 2'h2
`define CSB_CYC_SKIP2 2'h3
`define CSB_CYC_BR_TAKEN 2'h2
`define CSB_PC_STEP 16'h0001
`define CSB_PC_SKIP1 16'h0002
`define CSB_PC_SKIP2 16'h0003

`endif

//--- hw/csb_pkg.sv
package csb_pkg;

	typedef enum logic [3:0] {
		op_none,
		op_compare_with_carry,
		op_compare_immediate,
		op_skip_reg_bit_clear,
		op_skip_reg_bit_set,
		op_skip_io_bit_clear,
		op_skip_io_bit_set,
		op_branch_status_bit_set,
		op_branch_status_bit_clear,
		op_branch_equal,
		op_branch_not_equal,
		op_branch_carry_set
	} csb_op_t;

	// one decoded instruction as handed over by the decoder
	typedef struct packed {
		csb_op_t op;
		logic [7:0] rd;
		logic [7:0] rr;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [7:0] io_val;
		logic [6:0] offset;
		logic next_two_word;
		logic [15:0] pc;
	} csb_instr_t;

	// answer to the program counter
	typedef struct packed {
		logic done;
		logic taken;
		logic [15:0] pc;
	} csb_result_t;

	typedef enum logic {
		st_idle,
		st_stall
	} csb_state_t;

	typedef struct packed {
		csb_state_t st;
		logic [1:0] cnt;
		logic [7:0] flags;
		logic en;
		logic [15:0] pc;
		logic done;
		logic taken;
		logic [1:0] last_cyc;
		logic ack;
		logic [31:0] dat;
	} csb_regs_t;

endpackage

//--- hw/csb_unit.sv
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "csb_consts.svh"

module csb_unit
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// decoder side
	input wire logic issue_i,
	input wire csb_pkg::csb_instr_t ins_i,
	output logic ready_o,
	// program counter and status flags side
	output csb_pkg::csb_result_t res_o,
	output logic [7:0] flags_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	csb_pkg::csb_regs_t q_r;
	csb_pkg::csb_regs_t q_nxt;

	logic acc;
	logic [7:0] cmp_b;
	logic cmp_cin;
	logic cmp_c;
	logic cmp_h;
	logic cmp_v;
	logic cmp_n;
	logic cmp_z;
	logic is_cmp;
	logic cond;
	logic [1:0] ex_cyc;
	logic [15:0] ex_pc;
	logic [15:0] br_pc;
	logic [15:0] skip_pc;
	logic wb_req;
	logic wb_wr;

	// ----------------------------------------------------------------
	// compare datapath
	// ----------------------------------------------------------------
	assign is_cmp = (ins_i.op == csb_pkg::op_compare_with_carry) ||
		(ins_i.op == csb_pkg::op_compare_immediate);
	assign cmp_b = (ins_i.op == csb_pkg::op_compare_immediate) ?
		ins_i.imm : ins_i.rr;
	assign cmp_cin = (ins_i.op == csb_pkg::op_compare_with_carry) &
		q_r.flags[`CSB_FLAG_C];

	csb_cmp_sub i_csb_cmp_sub
	(
		.a_i(ins_i.rd),
		.b_i(cmp_b),
		.cin_i(cmp_cin),
		.res_o(),
		.c_o(cmp_c),
		.h_o(cmp_h),
		.v_o(cmp_v),
		.n_o(cmp_n),
		.z_o(cmp_z)
	);

	// ----------------------------------------------------------------
	// condition, cycle count and next counter value
	// ----------------------------------------------------------------
	// branch target wraps in the 16-bit word space like the counter does
	assign br_pc = ins_i.pc + {{9{ins_i.offset[6]}}, ins_i.offset} +
		`CSB_PC_STEP;
	assign skip_pc = ins_i.pc + (ins_i.next_two_word ?
		`CSB_PC_SKIP2 : `CSB_PC_SKIP1);

	always_comb
	begin
		cond = 1'b0;
		unique case (ins_i.op)
			csb_pkg::op_skip_reg_bit_clear:
				cond = ~ins_i.rr[ins_i.bit_sel];
			csb_pkg::op_skip_reg_bit_set:
				cond = ins_i.rr[ins_i.bit_sel];
			csb_pkg::op_skip_io_bit_clear:
				cond = ~ins_i.io_val[ins_i.bit_sel];
			csb_pkg::op_skip_io_bit_set:
				cond = ins_i.io_val[ins_i.bit_sel];
			csb_pkg::op_branch_status_bit_set:
				cond = q_r.flags[ins_i.bit_sel];
			csb_pkg::op_branch_status_bit_clear:
				cond = ~q_r.flags[ins_i.bit_sel];
			csb_pkg::op_branch_equal:
				cond = q_r.flags[`CSB_FLAG_Z];
			csb_pkg::op_branch_not_equal:
				cond = ~q_r.flags[`CSB_FLAG_Z];
			csb_pkg::op_branch_carry_set:
				cond = q_r.flags[`CSB_FLAG_C];
			default:
				cond = 1'b0;
		endcase
	end

	always_comb
	begin
		ex_cyc = `CSB_CYC_ONE;
		ex_pc = ins_i.pc + `CSB_PC_STEP;
		unique case (ins_i.op)
			csb_pkg::op_skip_reg_bit_clear,
			csb_pkg::op_skip_reg_bit_set,
			csb_pkg::op_skip_io_bit_clear,
			csb_pkg::op_skip_io_bit_set:
				if (cond)
				begin
					ex_cyc = ins_i.next_two_word ?
						`CSB_CYC_SKIP2 : `CSB_CYC_SKIP1;
					ex_pc = skip_pc;
				end
			csb_pkg::op_branch_status_bit_set,
			csb_pkg::op_branch_status_bit_clear,
			csb_pkg::op_branch_equal,
			csb_pkg::op_branch_not_equal,
			csb_pkg::op_branch_carry_set:
				if (cond)
				begin
					ex_cyc = `CSB_CYC_BR_TAKEN;
					ex_pc = br_pc;
				end
			default:
			begin
				ex_cyc = `CSB_CYC_ONE;
				ex_pc = ins_i.pc + `CSB_PC_STEP;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state update
	// ----------------------------------------------------------------
	// ready drops while stalled so the decoder holds the next instruction
	assign ready_o = (q_r.st == csb_pkg::st_idle) & q_r.en;
	assign acc = issue_i & ready_o;
	assign wb_req = wb_cyc_i & wb_stb_i & ~q_r.ack;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

	always_comb
	begin
		q_nxt = q_r;
		q_nxt.done = 1'b0;
		q_nxt.ack = wb_req;
		if (wb_req)
		begin
			unique case (wb_adr_i)
				`CSB_ADR_FLAGS:
					q_nxt.dat = {24'h00_0000, q_r.flags};
				`CSB_ADR_STATUS:
					q_nxt.dat = {28'h000_0000, q_r.last_cyc, q_r.taken,
						q_r.st == csb_pkg::st_stall};
				`CSB_ADR_CTRL:
					q_nxt.dat = {31'h0000_0000, q_r.en};
				default:
					q_nxt.dat = 32'h0000_0000;
			endcase
		end
		if (wb_wr && wb_adr_i == `CSB_ADR_FLAGS)
			q_nxt.flags = wb_dat_i[7:0];
		if (wb_wr && wb_adr_i == `CSB_ADR_CTRL)
			q_nxt.en = wb_dat_i[`CSB_CTRL_EN];
		unique case (q_r.st)
			csb_pkg::st_idle:
				if (acc)
				begin
					q_nxt.pc = ex_pc;
					q_nxt.taken = ex_cyc != `CSB_CYC_ONE;
					q_nxt.last_cyc = ex_cyc;
					q_nxt.cnt = ex_cyc - `CSB_CYC_ONE;
					if (ex_cyc == `CSB_CYC_ONE)
						q_nxt.done = 1'b1;
					else
						q_nxt.st = csb_pkg::st_stall;
					// a core compare wins over a software write in the
					// same cycle; z is chained for multi-byte compares
					if (is_cmp)
					begin
						q_nxt.flags[`CSB_FLAG_C] = cmp_c;
						q_nxt.flags[`CSB_FLAG_H] = cmp_h;
						q_nxt.flags[`CSB_FLAG_V] = cmp_v;
						q_nxt.flags[`CSB_FLAG_N] = cmp_n;
						q_nxt.flags[`CSB_FLAG_Z] = cmp_z &
							((ins_i.op != csb_pkg::op_compare_with_carry) |
							q_r.flags[`CSB_FLAG_Z]);
					end
				end
			csb_pkg::st_stall:
			begin
				q_nxt.cnt = q_r.cnt - 2'h1;
				if (q_r.cnt == 2'h1)
				begin
					q_nxt.done = 1'b1;
					q_nxt.st = csb_pkg::st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q_r <= '0;
			q_r.st <= csb_pkg::st_idle;
			q_r.flags <= `CSB_FLAGS_RST;
			q_r.en <= `CSB_CTRL_EN_RST;
		end
		else
			q_r <= q_nxt;
	end

	assign res_o.done = q_r.done;
	assign res_o.taken = q_r.taken;
	assign res_o.pc = q_r.pc;
	assign flags_o = q_r.flags;
	assign wb_dat_o = q_r.dat;
	assign wb_ack_o = q_r.ack;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_cmp_flags: assert property (acc && is_cmp |=> res_o.done &&
		flags_o[`CSB_FLAG_C] == $past(cmp_c) &&
		flags_o[`CSB_FLAG_N] == $past(cmp_n))
		else $error("compare flags or timing wrong");
	chk_reg_clr_skip: assert property (acc &&
		ins_i.op == csb_pkg::op_skip_reg_bit_clear &&
		!ins_i.rr[ins_i.bit_sel] && !ins_i.next_two_word
		|=> !res_o.done ##1 res_o.done &&
		res_o.pc == 16'($past(ins_i.pc, 2) + 16'h0002))
		else $error("register bit clear skip wrong");
	chk_flags_kept: assert property (acc && !is_cmp && !wb_wr
		|=> flags_o == $past(flags_o))
		else $error("skip or branch changed flags");
	chk_io_clr_skip: assert property (acc &&
		ins_i.op == csb_pkg::op_skip_io_bit_clear &&
		!ins_i.io_val[ins_i.bit_sel] && ins_i.next_two_word
		|=> !res_o.done [*2] ##1 res_o.done &&
		res_o.pc == 16'($past(ins_i.pc, 3) + 16'h0003))
		else $error("io bit clear skip wrong");
	chk_io_set_skip: assert property (acc &&
		ins_i.op == csb_pkg::op_skip_io_bit_set &&
		ins_i.io_val[ins_i.bit_sel] |=> !ready_o)
		else $error("io bit set did not skip");
	chk_stat_set_take: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_status_bit_set &&
		flags_o[ins_i.bit_sel] |-> ##2 res_o.done && res_o.taken &&
		res_o.pc == 16'($past(ins_i.pc, 2) +
		16'($signed($past(ins_i.offset, 2))) + 16'h0001))
		else $error("status bit set branch wrong");
	chk_stat_clr_fall: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_status_bit_clear &&
		flags_o[ins_i.bit_sel] |=> res_o.done && !res_o.taken &&
		res_o.pc == 16'($past(ins_i.pc) + 16'h0001))
		else $error("status bit clear fall-through wrong");
	chk_eq_branch: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_equal |=>
		res_o.done == !$past(flags_o[`CSB_FLAG_Z]))
		else $error("equal branch timing wrong");
	chk_ne_branch: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_not_equal |=>
		res_o.done == $past(flags_o[`CSB_FLAG_Z]))
		else $error("not equal branch timing wrong");
	chk_carry_branch: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_carry_set &&
		flags_o[`CSB_FLAG_C] |=> !ready_o ##1 res_o.taken)
		else $error("carry set branch wrong");
	chk_skip_false: assert property (acc &&
		ins_i.op == csb_pkg::op_skip_reg_bit_set &&
		!ins_i.rr[ins_i.bit_sel] |=> res_o.done && !res_o.taken &&
		res_o.pc == 16'($past(ins_i.pc) + 16'h0001))
		else $error("false skip not one cycle");
	chk_branch_back: assert property (acc &&
		ins_i.op == csb_pkg::op_branch_equal && ins_i.offset[6] &&
		flags_o[`CSB_FLAG_Z] |-> ##2 res_o.pc <= $past(ins_i.pc, 2) ||
		$past(ins_i.pc, 2) < 16'h0040)
		else $error("backward branch went forward");

	cov_cmp: cover property (acc &&
		ins_i.op == csb_pkg::op_compare_with_carry);
	cov_skip2: cover property (acc && cond && ins_i.next_two_word &&
		ins_i.op == csb_pkg::op_skip_reg_bit_set);
	cov_br_taken: cover property (acc && cond &&
		ins_i.op == csb_pkg::op_branch_carry_set);

endmodule

//--- verif/csb_unit_tb.sv
`timescale 1ns/1ps

module csb_unit_tb;

// ----------------------------------------------------------------
// stimulus and observed signals
// ----------------------------------------------------------------
logic clk_i, rst_i, issue_i, ready_o;
csb_pkg::csb_instr_t ins_i;
csb_pkg::csb_result_t res_o;
logic [7:0] flags_o, fv;
logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
logic [3:0] wb_adr_i, wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, q;
logic [6:0] k;
int n_fail, samples_checked, n;

csb_unit i_csb_unit (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i),
	.ins_i(ins_i), .ready_o(ready_o), .res_o(res_o), .flags_o(flags_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

initial
begin
	clk_i = 1'b0;
	forever #12.5 clk_i = ~clk_i;
end

// ----------------------------------------------------------------
// shared helpers
// ----------------------------------------------------------------
task complete_run;
	$display("checked %0d failed %0d", samples_checked, n_fail);
	if (n_fail == 0 && samples_checked > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask

task chk(input logic [31:0] g, input logic [31:0] x, input string m);
	samples_checked++;
	if (g !== x)
	begin
		n_fail++;
		$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
	end
endtask

// classic cycle: hold until ack is seen, then drop for one idle cycle
task wb(input logic w, input logic [3:0] a, input logic [3:0] s,
	input logic [31:0] d);
	int j;
	@(posedge clk_i);
	wb_cyc_i <= 1'b1;
	wb_stb_i <= 1'b1;
	wb_we_i <= w;
	wb_adr_i <= a;
	wb_sel_i <= s;
	wb_dat_i <= d;
	j = 0;
	do
	begin
		@(posedge clk_i);
		j++;
	end
	while (wb_ack_o !== 1'b1 && j < 20);
	chk(j, 2, "ack delay");
	q = wb_dat_o;
	wb_cyc_i <= 1'b0;
	wb_stb_i <= 1'b0;
	wb_we_i <= 1'b0;
endtask

function automatic csb_pkg::csb_instr_t mk(input csb_pkg::csb_op_t o,
	input logic [7:0] a, input logic [7:0] c, input logic [2:0] b,
	input logic [6:0] kk, input logic tw);
	mk = '{op:o, rd:a, rr:c, imm:c, bit_sel:b, io_val:a, offset:kk,
		next_two_word:tw, pc:16'h0100};
endfunction

// decoder holds the offer until accepted; n counts cycles to done
task run(input csb_pkg::csb_instr_t x);
	logic ok;
	int j;
	@(posedge clk_i);
	ins_i <= x;
	issue_i <= 1'b1;
	j = 0;
	do
	begin
		@(negedge clk_i);
		ok = ready_o;
		j++;
		@(posedge clk_i);
	end
	while (ok !== 1'b1 && j < 20);
	issue_i <= 1'b0;
	chk(ok, 1'b1, "accepted");
	n = 0;
	do
	begin
		@(negedge clk_i);
		n++;
	end
	while (res_o.done !== 1'b1 && n < 10);
endtask

task cres(input int xn, input logic [15:0] xp, input logic [7:0] xf);
	chk(n, xn, "cycles");
	chk(res_o.pc, xp, "next pc");
	chk(flags_o, xf, "flags");
endtask

// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task t_reset;
	@(negedge clk_i);
	chk(ready_o, 1'b1, "ready");
	chk(res_o, 0, "result");
	chk(flags_o, 8'h00, "flags");
	wb(1'b1, 4'hc, 4'hf, 32'hffff_ffff);
	wb(1'b0, 4'hc, 4'hf, 32'h0000_0000);
	chk(q, 32'h0000_0000, "unmapped");
	wb(1'b0, 4'h8, 4'hf, 32'h0000_0000);
	chk(q, 32'h0000_0001, "ctrl");
endtask

task t_cmp;
	logic [7:0] ta [5], tc [5], tf [5];
	ta = '{8'h00, 8'h05, 8'h10, 8'h33, 8'h80};
	tc = '{8'h01, 8'h04, 8'h10, 8'h33, 8'h01};
	tf = '{8'h25, 8'h00, 8'h02, 8'h02, 8'h28};
	// odd entries chain on the carry and zero of the one before
	for (int i = 0; i < 5; i++)
	begin
		run(mk(i[0] ? csb_pkg::op_compare_with_carry :
			csb_pkg::op_compare_immediate, ta[i], tc[i], 3'h0, 7'h00, 1'b0));
		cres(1, 16'h0101, tf[i]);
	end
	run(mk(csb_pkg::op_none, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0));
	cres(1, 16'h0101, 8'h28);
	wb(1'b0, 4'h0, 4'hf, 32'h0000_0000);
	chk(q, 32'h0000_0028, "flags read");
endtask

task t_skip;
	bit s;
	int m;
	logic [15:0] p;
	wb(1'b1, 4'h0, 4'h0, 32'h0000_00ff);
	wb(1'b1, 4'h0, 4'h1, 32'h0000_0025);
	chk(flags_o, 8'h25, "flags write");
	for (int i = 0; i < 4; i++)
		for (int b = 3; b < 5; b++)
			for (int tw = 0; tw < 2; tw++)
			begin
				s = i[0] ? (b == 4) : (b != 4);
				m = s ? 2 + tw : 1;
				run(mk(csb_pkg::csb_op_t'(csb_pkg::op_skip_reg_bit_clear + 4'(i)),
					8'h10, 8'h10, 3'(b), 7'h00, 1'(tw)));
				p = 16'h0100 + 16'(m);
				cres(m, p, 8'h25);
				chk(res_o.taken, s, "skip taken");
			end
	wb(1'b0, 4'h4, 4'hf, 32'h0000_0000);
	chk(q, 32'h0000_000e, "status");
endtask

task br(input csb_pkg::csb_op_t o, input int b, input logic t);
	run(mk(o, 8'h00, 8'h00, 3'(b), k, 1'b0));
	cres(t ? 2 : 1, 16'h0101 + (t ? {{9{k[6]}}, k} : 16'h0000), fv);
	chk(res_o.taken, t, "branch taken");
endtask

task t_br;
	for (int v = 0; v < 2; v++)
	begin
		fv = v ? 8'h5a : 8'ha5;
		wb(1'b1, 4'h0, 4'h1, {24'h00_0000, fv});
		for (int b = 0; b < 8; b++)
		begin
			k = b[0] ? 7'h7e : 7'h05;
			br(csb_pkg::op_branch_status_bit_set, b, fv[b]);
			br(csb_pkg::op_branch_status_bit_clear, b, !fv[b]);
		end
		br(csb_pkg::op_branch_equal, 0, fv[1]);
		br(csb_pkg::op_branch_not_equal, 0, !fv[1]);
		br(csb_pkg::op_branch_carry_set, 0, fv[0]);
	end
endtask

task t_en;
	wb(1'b1, 4'h8, 4'h1, 32'h0000_0000);
	@(negedge clk_i);
	chk(ready_o, 1'b0, "ready off");
	// an offer while disabled must be ignored and leave the flags alone
	@(posedge clk_i);
	ins_i <= mk(csb_pkg::op_compare_immediate, 8'h00, 8'h01, 3'h0, 7'h00,
		1'b0);
	issue_i <= 1'b1;
	repeat (3)
	begin
		@(negedge clk_i);
		chk(res_o.done, 1'b0, "refused done");
	end
	chk(flags_o, fv, "refused flags");
	@(posedge clk_i);
	issue_i <= 1'b0;
	wb(1'b1, 4'h8, 4'h1, 32'h0000_0001);
	@(negedge clk_i);
	chk(ready_o, 1'b1, "ready on");
endtask

initial
begin
	rst_i = 1'b1;
	issue_i = 1'b0;
	ins_i = '0;
	wb_cyc_i = 1'b0;
	wb_stb_i = 1'b0;
	wb_we_i = 1'b0;
	wb_adr_i = 4'h0;
	wb_sel_i = 4'h0;
	wb_dat_i = 32'h0000_0000;
	repeat (4) @(posedge clk_i);
	rst_i <= 1'b0;
	t_reset;
	t_cmp;
	t_skip;
	t_br;
	t_en;
	complete_run;
end

// whole run needs well under two thousand cycles
initial
begin
	#(25 * 5000);
	n_fail++;
	complete_run;
end

endmodule
